//--- core/luc_pkg.sv
// Package for the serial-port control register block.
// Assumes an 8-bit register port with 12-bit byte addresses.
package luc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam logic [11:0] SERIAL_PORT0_CONTROL_ADDR = 12'hF42;
  localparam logic [11:0] SERIAL_PORT1_CONTROL_ADDR = 12'hF4A;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Field positions of the control register
  localparam int unsigned BIT_TRANSMITTER_ON = 7;
  localparam int unsigned BIT_RECEIVER_ON = 6;
  localparam int unsigned BIT_CLEAR_TO_SEND_GATE_ON = 5;
  localparam int unsigned BIT_PARITY_ON = 4;
  localparam int unsigned BIT_PARITY_ODD = 3;
  localparam int unsigned BIT_SEND_LINE_BREAK = 2;
  localparam int unsigned BIT_STOP_SELECT = 1;
  localparam int unsigned BIT_LOOPBACK_ON = 0;
endpackage : luc_pkg

//--- core/luc_port_ctl.sv
// One serial port's control register and the enables derived from it.
// Assumes clear_to_send_n_i is already synchronised to core_clk_i.
`timescale 1ns/1ns
module luc_port_ctl (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic clear_to_send_n_i,
  input wire logic multiprocessor_mode_on_i,
  output logic [7:0] ctl_q_o,
  output logic tx_run_d_o,
  output logic rx_run_d_o,
  output logic parity_bit_d_o,
  output logic parity_odd_d_o
);
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic cts_gate;

  assign ctl_d = wr_en_i ? wdata_i : ctl_q;
  assign cts_gate = ctl_q[luc_pkg::BIT_CLEAR_TO_SEND_GATE_ON] ? ~clear_to_send_n_i
                  : 1'b1;
  assign tx_run_d_o = ctl_q[luc_pkg::BIT_TRANSMITTER_ON] & cts_gate;
  assign rx_run_d_o = ctl_q[luc_pkg::BIT_RECEIVER_ON];
  assign parity_bit_d_o = ctl_q[luc_pkg::BIT_PARITY_ON] & ~multiprocessor_mode_on_i;
  assign parity_odd_d_o = ctl_q[luc_pkg::BIT_PARITY_ODD];
  assign ctl_q_o = ctl_q;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ctl_q <= luc_pkg::CONTROL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end
endmodule : luc_port_ctl

//--- core/luc_top.sv
// Control registers for two serial ports: enables and parity setup.
// Assumes a single-cycle register port; clear-to-send pins are asynchronous.
//
// Behaviour
// - Each port has an 8-bit read/write control register at F42 or F4A, reset to zero.
// - Bit 7 enables the transmitter, subject to clear-to-send gating.
// - With bit 5 set, the transmitter runs only while the clear-to-send input is low.
// - With bit 5 clear, the clear-to-send input has no effect.
// - Bit 6 enables the receiver.
// - Bit 4 adds one parity bit to sent and expected characters.
// - Multiprocessor mode overrides the parity enable.
// - Bit 3 selects even parity at 0 and odd at 1, for both directions.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module luc_top #(
  parameter int unsigned PORTS = 2
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [PORTS-1:0] clear_to_send_n_i,
  input wire logic [PORTS-1:0] multiprocessor_mode_on_i,
  output logic [PORTS-1:0] transmitter_on_o,
  output logic [PORTS-1:0] receiver_on_o,
  output logic [PORTS-1:0] parity_on_o,
  output logic [PORTS-1:0] parity_odd_o,
  output logic [PORTS-1:0] send_line_break_o,
  output logic [PORTS-1:0] stop_select_o,
  output logic [PORTS-1:0] loopback_on_o
);
  logic [PORTS-1:0] cts_meta_q;
  logic [PORTS-1:0] cts_sync_q;
  logic [7:0] ctl [PORTS];
  logic [PORTS-1:0] tx_d;
  logic [PORTS-1:0] rx_d;
  logic [PORTS-1:0] par_d;
  logic [PORTS-1:0] odd_d;
  logic [PORTS-1:0] sel;
  logic [7:0] rdata_d;
  logic [11:0] port_addr [2];

  assign port_addr[0] = luc_pkg::SERIAL_PORT0_CONTROL_ADDR;
  assign port_addr[1] = luc_pkg::SERIAL_PORT1_CONTROL_ADDR;

  // Clear-to-send comes from a pin: two flops before use
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cts_meta_q <= '1;
      cts_sync_q <= '1;
    end else begin
      cts_meta_q <= clear_to_send_n_i;
      cts_sync_q <= cts_meta_q;
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    assign sel[p] = (addr_i == port_addr[p]);
    luc_port_ctl u_ctl (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .wr_en_i(wr_i & sel[p]),
      .wdata_i(wdata_i),
      .clear_to_send_n_i(cts_sync_q[p]),
      .multiprocessor_mode_on_i(multiprocessor_mode_on_i[p]),
      .ctl_q_o(ctl[p]),
      .tx_run_d_o(tx_d[p]),
      .rx_run_d_o(rx_d[p]),
      .parity_bit_d_o(par_d[p]),
      .parity_odd_d_o(odd_d[p])
    );
  end

  // Unmapped addresses read as zero
  always_comb begin
    rdata_d = 8'h00;
    for (int p = 0; p < PORTS; p++) begin
      if (sel[p]) begin
        rdata_d = ctl[p];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      transmitter_on_o <= '0;
      receiver_on_o <= '0;
      parity_on_o <= '0;
      parity_odd_o <= '0;
      send_line_break_o <= '0;
      stop_select_o <= '0;
      loopback_on_o <= '0;
    end else begin
      rdata_o <= rd_i ? rdata_d : 8'h00;
      transmitter_on_o <= tx_d;
      receiver_on_o <= rx_d;
      parity_on_o <= par_d;
      parity_odd_o <= odd_d;
      for (int p = 0; p < PORTS; p++) begin
        send_line_break_o[p] <= ctl[p][luc_pkg::BIT_SEND_LINE_BREAK];
        stop_select_o[p] <= ctl[p][luc_pkg::BIT_STOP_SELECT];
        loopback_on_o[p] <= ctl[p][luc_pkg::BIT_LOOPBACK_ON];
      end
    end
  end

  chk_read_back_value: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_i && addr_i == luc_pkg::SERIAL_PORT0_CONTROL_ADDR) ##1
    (rd_i && addr_i == luc_pkg::SERIAL_PORT0_CONTROL_ADDR)
    |=> rdata_o == $past(wdata_i, 2))
    else $error("control read-back mismatch");
  chk_unmapped_read_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (rd_i && sel == '0) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_tx_off_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !ctl[0][luc_pkg::BIT_TRANSMITTER_ON] |=> !transmitter_on_o[0])
    else $error("transmitter on with enable clear");
  chk_cts_gates_tx: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ctl[0][luc_pkg::BIT_CLEAR_TO_SEND_GATE_ON] && cts_sync_q[0]) |=> !transmitter_on_o[0])
    else $error("transmitter on with clear-to-send high");
  chk_cts_ignored: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (!ctl[0][luc_pkg::BIT_CLEAR_TO_SEND_GATE_ON] && ctl[0][luc_pkg::BIT_TRANSMITTER_ON])
    |=> transmitter_on_o[0])
    else $error("clear-to-send not ignored");
  chk_rx_follows_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    receiver_on_o[1] == $past(ctl[1][luc_pkg::BIT_RECEIVER_ON]))
    else $error("receiver enable mismatch");
  chk_mp_overrides_par: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    multiprocessor_mode_on_i[0] |=> !parity_on_o[0])
    else $error("parity active in multiprocessor mode");
  chk_parity_follows: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ctl[1][luc_pkg::BIT_PARITY_ON] && !multiprocessor_mode_on_i[1]) |=> parity_on_o[1])
    else $error("parity enable not passed");
  chk_parity_sense: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    parity_odd_o[0] == $past(ctl[0][luc_pkg::BIT_PARITY_ODD]))
    else $error("parity select mismatch");
  chk_misc_bits_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    loopback_on_o[1] == $past(ctl[1][luc_pkg::BIT_LOOPBACK_ON]))
    else $error("loopback bit mismatch");

  chk_rdata_idle_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero between reads");

  // Same guards for every port, pin synchroniser included
  for (genvar p = 0; p < PORTS; p++) begin : g_chk
    chk_reset_clears: assert property (@(posedge core_clk_i)
      !rstn_i
      |=> ctl[p] == luc_pkg::CONTROL_RESET)
      else $error("control register not cleared by reset");
    chk_reset_quiet: assert property (@(posedge core_clk_i)
      !rstn_i
      |=> !(transmitter_on_o[p] || receiver_on_o[p] || parity_on_o[p]))
      else $error("enables active during reset");
    chk_write_lands: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (wr_i && sel[p])
      |=> ctl[p] == $past(wdata_i))
      else $error("control write not stored");
    chk_ctl_holds: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !(wr_i && sel[p])
      |=> $stable(ctl[p]))
      else $error("control changed without a write");
    chk_read_selects: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (rd_i && sel[p])
      |=> rdata_o == $past(ctl[p]))
      else $error("read data not from addressed port");
    chk_cts_two_flops: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ($past(rstn_i) && $past(rstn_i, 2))
      |-> cts_sync_q[p] == $past(clear_to_send_n_i[p], 2))
      else $error("clear-to-send synchroniser delay wrong");
    chk_tx_needs_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !ctl[p][luc_pkg::BIT_TRANSMITTER_ON]
      |=> !transmitter_on_o[p])
      else $error("transmitter on without its enable");
    chk_tx_gated_cts: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ctl[p][luc_pkg::BIT_CLEAR_TO_SEND_GATE_ON] && cts_sync_q[p])
      |=> !transmitter_on_o[p])
      else $error("transmitter on while clear-to-send is high");
    chk_tx_cts_low: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ctl[p][luc_pkg::BIT_TRANSMITTER_ON]
      && ctl[p][luc_pkg::BIT_CLEAR_TO_SEND_GATE_ON] && !cts_sync_q[p])
      |=> transmitter_on_o[p])
      else $error("transmitter off while clear-to-send is low");
    chk_cts_no_effect: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ctl[p][luc_pkg::BIT_TRANSMITTER_ON]
      && !ctl[p][luc_pkg::BIT_CLEAR_TO_SEND_GATE_ON])
      |=> transmitter_on_o[p])
      else $error("clear-to-send acted with its gate off");
    chk_rx_on_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ctl[p][luc_pkg::BIT_RECEIVER_ON]
      |=> receiver_on_o[p])
      else $error("receiver off with its enable set");
    chk_rx_off_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !ctl[p][luc_pkg::BIT_RECEIVER_ON]
      |=> !receiver_on_o[p])
      else $error("receiver on with its enable clear");
    chk_parity_on_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ctl[p][luc_pkg::BIT_PARITY_ON] && !multiprocessor_mode_on_i[p])
      |=> parity_on_o[p])
      else $error("parity off with its enable set");
    chk_parity_off_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !ctl[p][luc_pkg::BIT_PARITY_ON]
      |=> !parity_on_o[p])
      else $error("parity on with its enable clear");
    chk_mp_wins: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      multiprocessor_mode_on_i[p]
      |=> !parity_on_o[p])
      else $error("parity on in multiprocessor mode");
    chk_parity_odd_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      parity_odd_o[p] == $past(ctl[p][luc_pkg::BIT_PARITY_ODD]))
      else $error("parity sense not from its select bit");
    chk_break_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      send_line_break_o[p] == $past(ctl[p][luc_pkg::BIT_SEND_LINE_BREAK]))
      else $error("break bit not passed unchanged");
    chk_stop_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      stop_select_o[p] == $past(ctl[p][luc_pkg::BIT_STOP_SELECT]))
      else $error("stop select bit not passed unchanged");
    chk_loop_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      loopback_on_o[p] == $past(ctl[p][luc_pkg::BIT_LOOPBACK_ON]))
      else $error("loopback bit not passed unchanged");
  end
endmodule : luc_top

//--- bench/luc_remote_node.sv
// Remote serial node: drives the clear-to-send pins of both ports.
// Assumes the bench commands readiness; pins change off the clock edge.
`timescale 1ns/1ns
module luc_remote_node (
  input wire logic core_clk_i,
  input wire logic [1:0] ready_i,
  output logic [1:0] clear_to_send_n_o
);
  // Low means ready to take characters; skewed to look asynchronous
  always @(posedge core_clk_i) clear_to_send_n_o <= #3 ~ready_i;
endmodule : luc_remote_node

//--- bench/lin_uart_control_bench.sv
// Self-checking bench for the serial-port control registers.
// Assumes luc_top with two ports and the remote node model.
`timescale 1ns/1ns
module lin_uart_control_bench;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] mp = 2'h0;
  logic [1:0] ready = 2'h0;
  logic [1:0] cts_n;
  logic [7:0] rdata_o;
  logic [1:0] tx, rx, par, odd, brk, stp, lb;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h5256AF25;
  logic [7:0] regs [2];
  logic [7:0] corner [4] = '{8'hA0, 8'h80, 8'hFF, 8'h18};
  logic [7:0] d;
  logic p;
  logic [11:0] pa;
  luc_remote_node u_node (.core_clk_i(core_clk_i), .ready_i(ready), .clear_to_send_n_o(cts_n));
  luc_top u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .clear_to_send_n_i(cts_n), .multiprocessor_mode_on_i(mp), .transmitter_on_o(tx),
    .receiver_on_o(rx), .parity_on_o(par), .parity_odd_o(odd), .send_line_break_o(brk),
    .stop_select_o(stp), .loopback_on_o(lb));
  always #4 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] exp_out(input logic [7:0] r, input logic rdy, input logic m);
    return {1'b0, r[7] & (~r[5] | rdy), r[6], r[4] & ~m, r[3], r[2], r[1], r[0]};
  endfunction : exp_out
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    cmp("rdata", e, rdata_o);
  endtask : rd
  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    cmp("rdata_b2b", v, rdata_o);
  endtask : wr_rd
  task automatic outs(input int q);
    logic [7:0] want;
    logic [7:0] seen;
    want = exp_out(regs[q], ready[q], mp[q]);
    seen = {1'b0, tx[q], rx[q], par[q], odd[q], brk[q], stp[q], lb[q]};
    cmp("outputs", want, seen);
  endtask : outs
  task automatic close_out;
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    regs[0] = 8'h00;
    regs[1] = 8'h00;
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(luc_pkg::SERIAL_PORT0_CONTROL_ADDR, 8'h00);
    rd(luc_pkg::SERIAL_PORT1_CONTROL_ADDR, 8'h00);
    for (int i = 0; i < 80; i++) begin
      seed = xs(seed);
      p = seed[8];
      d = (i < 8) ? corner[i % 4] : seed[31:24];
      pa = p ? luc_pkg::SERIAL_PORT1_CONTROL_ADDR : luc_pkg::SERIAL_PORT0_CONTROL_ADDR;
      @(posedge core_clk_i);
      mp <= seed[10:9];
      ready <= seed[12:11];
      wr(pa, d);
      regs[p] = d;
      wr(12'hF43, seed[23:16]);
      repeat (5) @(posedge core_clk_i);
      #1;
      outs(0);
      outs(1);
      rd(pa, d);
      rd(12'hF4B, 8'h00);
      wr_rd(pa, seed[7:0]);
      regs[p] = seed[7:0];
    end
    // Reset in mid-run: registers and enables return to zero
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    regs[0] = 8'h00;
    regs[1] = 8'h00;
    rd(luc_pkg::SERIAL_PORT0_CONTROL_ADDR, 8'h00);
    rd(luc_pkg::SERIAL_PORT1_CONTROL_ADDR, 8'h00);
    outs(0);
    outs(1);
    close_out;
  end
endmodule : lin_uart_control_bench
